// >>> logic/dfr_diag_flags.sv
// digital and analog diagnostic flag registers behind the serial port
module dfr_diag_flags (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // interface configuration
  input wire logic crc_enable,
  // calibration memory and dac core
  input wire logic cal_refresh_busy,
  input wire logic cal_crc_fail,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] dac_code_inv,
  // analog fault sources and their enables, by flag position
  input wire logic [15:0] ana_fault_src,
  input wire logic [15:0] ana_diag_en,
  // fault pin level
  input wire logic fault_pin,
  // summary
  output logic digital_fault_summary
);

  //--------------------------------------------------------------------
  // frame receiver
  //--------------------------------------------------------------------
  logic frame_done;  // one pulse at frame end
  logic [31:0] frame_word;  // bits shifted in, last bit at 0
  logic [5:0] edge_count;  // falling edges seen
  logic [23:0] resp_r;  // readback word for next frame

  dfr_spi_rx u_rx (
    .ref_clk(ref_clk),
    .srst(srst),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .sdo(sdo),
    .tx_word(resp_r),
    .frame_done(frame_done),
    .frame_word(frame_word),
    .edge_count(edge_count)
  );

  //--------------------------------------------------------------------
  // fault pin synchroniser, three stages
  //--------------------------------------------------------------------
  logic fp1_r;  // first stage, read only by fp2
  logic fp2_r;
  logic fp3_r;
  logic fpin_r;  // accepted pin level

  // accept a change once stage two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      fp1_r <= 1'b1;
      fp2_r <= 1'b1;
      fp3_r <= 1'b1;
      fpin_r <= 1'b1;
    end
    else
    begin
      fp1_r <= fault_pin;
      fp2_r <= fp1_r;
      fp3_r <= fp2_r;
      fpin_r <= (fp2_r == fp3_r) ? fp3_r : fpin_r;
    end
  end

  //--------------------------------------------------------------------
  // crc over the 24 payload bits, msb first
  //--------------------------------------------------------------------
  function automatic logic [7:0] dfr_crc8(input logic [23:0] data);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
    begin
      c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ dfr_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : dfr_crc8

  //--------------------------------------------------------------------
  // frame checks
  //--------------------------------------------------------------------
  wire is_long = (edge_count == dfr_pkg::LEN_LONG);
  wire is_short = (edge_count == dfr_pkg::LEN_SHORT);
  // clock count: 32 with crc, 24 or 32 without
  // edge count check
  wire cnt_ok = is_long | (is_short & ~crc_enable);
  wire [23:0] payload = is_long ? frame_word[31:8] : frame_word[23:0];
  wire [7:0] crc_rx = frame_word[7:0];
  wire crc_bad = crc_enable & (dfr_crc8(payload) != crc_rx);
  wire slip_bad = (payload[dfr_pkg::SLIP_BIT] == payload[dfr_pkg::SLIP_BIT - 1]);
  wire frame_ok = frame_done & cnt_ok & ~crc_bad & ~slip_bad;

  // command fields
  wire is_read = payload[dfr_pkg::READ_BIT];
  wire [4:0] addr = payload[20:16];
  wire [15:0] wdata = payload[15:0];
  wire hit_dig = (addr == dfr_pkg::DIG_ADDR);
  wire hit_ana = (addr == dfr_pkg::ANA_ADDR);
  wire hit_ro = (addr == dfr_pkg::STAT_ADDR) | (addr == dfr_pkg::ID_ADDR);
  wire addr_ok = hit_dig | hit_ana | hit_ro;
  wire is_write = frame_ok & ~is_read;

  //--------------------------------------------------------------------
  // calibration refresh tracking
  //--------------------------------------------------------------------
  logic busy_d_r;  // refresh busy one cycle ago
  logic refreshed_r;  // a refresh has completed since reset

  // note when a refresh finishes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      busy_d_r <= 1'b0;
      refreshed_r <= 1'b0;
    end
    else
    begin
      busy_d_r <= cal_refresh_busy;
      if (busy_d_r & ~cal_refresh_busy)
      begin
        refreshed_r <= 1'b1;
      end
    end
  end

  wire wr_locked = ~refreshed_r | cal_refresh_busy;
  // reads never lock, so a readback during a refresh is clean
  // readback stays legal
  wire rd_bad = frame_ok & is_read & ~addr_ok;
  wire wr_bad = is_write & (~addr_ok | hit_ro | wr_locked);
  wire acc_bad = rd_bad | wr_bad;
  wire wr_take = is_write & ~wr_locked;

  //--------------------------------------------------------------------
  // flag set and clear vectors
  //--------------------------------------------------------------------
  logic [15:0] dig_set;
  logic [15:0] dig_clr;
  logic [15:0] ana_set;
  logic [15:0] ana_clr;

  // digital event collection
  always_comb
  begin
    dig_set = 16'h0000;
    dig_set[dfr_pkg::DIG_CRC_BIT] = frame_done & cnt_ok & crc_bad;
    dig_set[dfr_pkg::DIG_SLIP_BIT] = frame_done & cnt_ok & slip_bad;
    dig_set[dfr_pkg::DIG_CNT_BIT] = frame_done & ~cnt_ok;
    dig_set[dfr_pkg::DIG_ACC_BIT] = acc_bad;
    dig_set[dfr_pkg::DIG_CALCRC_BIT] = cal_crc_fail;
    dig_set[dfr_pkg::DIG_INV_BIT] = (dac_code != ~dac_code_inv);
  end

  // analog sources only count while their diagnostic is enabled
  // analog sources
  assign ana_set = ana_fault_src & ana_diag_en & dfr_pkg::ANA_MASK;
  assign dig_clr = (wr_take & hit_dig) ? wdata : 16'h0000;
  assign ana_clr = (wr_take & hit_ana) ? wdata : 16'h0000;

  //--------------------------------------------------------------------
  // sticky flag registers
  //--------------------------------------------------------------------
  logic [15:0] dig_r;
  logic [15:0] ana_r;
  logic [15:0] dig_nxt;
  logic [15:0] ana_nxt;

  // a set in the clearing cycle wins, so a live fault comes straight back
  // sticky write-one clear
  assign dig_nxt = ((dig_r & ~dig_clr) | dig_set) & dfr_pkg::DIG_MASK;
  assign ana_nxt = ((ana_r & ~ana_clr) | ana_set) & dfr_pkg::ANA_MASK;

  // flag storage
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      dig_r <= dfr_pkg::FLAG_RESET;
      ana_r <= dfr_pkg::ANA_RESET[15:0];
    end
    else
    begin
      dig_r <= dig_nxt;
      ana_r <= ana_nxt;
    end
  end

  //--------------------------------------------------------------------
  // readback word
  //--------------------------------------------------------------------
  logic [15:0] rd_data;
  logic [23:0] resp_nxt;
  logic sum_r;

  // disabled analog diagnostics read as zero
  // enable masking
  assign rd_data = hit_dig ? dig_r :
                   hit_ana ? (ana_r & ana_diag_en) : 16'h0000;
  assign resp_nxt = {2'b00, ~fpin_r, addr, rd_data};

  // capture on a good read, zeros after a good write; a bad frame leaves the word unchanged
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      resp_r <= 24'h000000;
    end
    else if (frame_ok)
    begin
      resp_r <= is_read ? resp_nxt : 24'h000000;
    end
  end

  // link errors at bits 2..0 stay out of the summary
  // summary of flags
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      sum_r <= 1'b0;
    end
    else
    begin
      sum_r <= |(dig_nxt & dfr_pkg::DIG_SUM_MASK);
    end
  end

  assign digital_fault_summary = sum_r;

endmodule : dfr_diag_flags

// >>> logic/dfr_pkg.sv
// constants shared by the diagnostic flag register block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package dfr_pkg;

  //--------------------------------------------------------------------
  // register addresses
  //--------------------------------------------------------------------
  localparam logic [4:0] DIG_ADDR = 5'h14;  // digital flags
  localparam logic [4:0] ANA_ADDR = 5'h15;  // analog flags
  localparam logic [4:0] STAT_ADDR = 5'h16;  // status, read only
  localparam logic [4:0] ID_ADDR = 5'h17;  // chip id, read only

  // reset values of the analog and digital flag registers
  localparam logic [21:0] ANA_RESET = 22'h150000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;

  //--------------------------------------------------------------------
  // digital flag positions
  //--------------------------------------------------------------------
  localparam int DIG_CRC_BIT = 0;
  localparam int DIG_SLIP_BIT = 1;
  localparam int DIG_CNT_BIT = 2;
  localparam int DIG_ACC_BIT = 4;
  localparam int DIG_CALCRC_BIT = 5;
  localparam int DIG_INV_BIT = 6;
  localparam logic [15:0] DIG_MASK = 16'h0077;  // implemented bits
  localparam logic [15:0] DIG_SUM_MASK = 16'h0070;  // bits seen by summary

  // analog flags live at 13,11,9,7,6,4,3,2,1,0
  localparam logic [15:0] ANA_MASK = 16'h2ADF;

  //--------------------------------------------------------------------
  // frame layout
  //--------------------------------------------------------------------
  localparam int SLIP_BIT = 23;  // must be inverse of bit 22
  localparam int READ_BIT = 21;  // high asks for a readback
  localparam int FLT_BIT = 21;  // fault pin position in readback
  localparam logic [5:0] LEN_SHORT = 6'h18;  // 24 edges
  localparam logic [5:0] LEN_LONG = 6'h20;  // 32 edges
  localparam logic [7:0] CRC_POLY = 8'h07;  // x^8+x^2+x+1

endpackage : dfr_pkg

// >>> logic/dfr_spi_rx.sv
// serial frame receiver with pin synchronisers and readback shifter
module dfr_spi_rx (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  // frame side
  input wire logic [23:0] tx_word,
  output logic frame_done,
  output logic [31:0] frame_word,
  output logic [5:0] edge_count
);

  //--------------------------------------------------------------------
  // three-stage synchronisers, one per pin
  //--------------------------------------------------------------------
  logic [2:0] pin_in;  // {sdi, cs_n, sclk}
  logic [2:0] s1_r;  // first stage, read only by s2
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;  // accepted level
  logic [2:0] prev_r;  // accepted level one cycle ago

  assign pin_in = {sdi, cs_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      // level accepted once stage two and three agree
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          s1_r[gi] <= 1'b1;
          s2_r[gi] <= 1'b1;
          s3_r[gi] <= 1'b1;
          filt_r[gi] <= 1'b1;
          prev_r[gi] <= 1'b1;
        end
        else
        begin
          s1_r[gi] <= pin_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          filt_r[gi] <= (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
          prev_r[gi] <= filt_r[gi];
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------
  // edge decode
  //--------------------------------------------------------------------
  wire sel_low = ~filt_r[1];
  wire clk_fall = prev_r[0] & ~filt_r[0] & sel_low;
  wire sel_fall = prev_r[1] & ~filt_r[1];
  wire sel_rise = ~prev_r[1] & filt_r[1];

  logic [23:0] txsh_r;  // readback shift register
  logic sdo_r;
  logic done_r;
  logic [31:0] word_r;
  logic [5:0] cnt_r;

  // receive side: count falling edges and shift data in
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      word_r <= 32'h00000000;
      cnt_r <= 6'h00;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= sel_rise;
      if (sel_fall)
      begin
        cnt_r <= 6'h00;
      end
      else if (clk_fall)
      begin
        word_r <= {word_r[30:0], filt_r[2]};
        cnt_r <= (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
      end
    end
  end

  // transmit side: load at frame start, next bit per falling edge
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      txsh_r <= 24'h000000;
      sdo_r <= 1'b0;
    end
    else if (sel_fall)
    begin
      txsh_r <= {tx_word[22:0], 1'b0};
      sdo_r <= tx_word[23];
    end
    else if (clk_fall)
    begin
      txsh_r <= {txsh_r[22:0], 1'b0};
      sdo_r <= txsh_r[23];
    end
    else if (filt_r[1])
    begin
      sdo_r <= 1'b0;
    end
  end

  assign sdo = sdo_r;
  assign frame_done = done_r;
  assign frame_word = word_r;
  assign edge_count = cnt_r;

endmodule : dfr_spi_rx

// >>> sim/dfr_diag_flags_checker.sv
// port assertions for the diagnostic flag block
module dfr_diag_flags_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // watched ports
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic cal_crc_fail,
  input wire logic [15:0] dac_code,
  input wire logic [15:0] dac_code_inv,
  input wire logic digital_fault_summary
);
  // a digital flag source is active
  wire logic src = cal_crc_fail || (dac_code != ~dac_code_inv);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_INV_SET: assert property ((dac_code != ~dac_code_inv) |-> ##[1:2] digital_fault_summary)
    else $error("inverse mismatch left summary low");
  AST_CAL_SET: assert property (cal_crc_fail |-> ##[1:2] digital_fault_summary)
    else $error("cal crc failure left summary low");
  AST_PERSIST: assert property (src [*3] |-> digital_fault_summary)
    else $error("persisting source not flagged");
  AST_HOLD: assert property ((cs_n && !src) [*8] ##1 (cs_n && !src) [*2] |=> $stable(digital_fault_summary))
    else $error("summary moved with no cause");
  AST_CLR: assert property ($fell(digital_fault_summary) |-> $past(cs_n, 4))
    else $error("summary cleared outside a frame end");
  AST_CAUSE: assert property ($rose(digital_fault_summary) |-> $past(src) || $past(src, 2) || $past(cs_n, 4))
    else $error("summary rose with no cause");
  AST_RST: assert property ($fell(srst) |-> !digital_fault_summary)
    else $error("summary high after reset");
  AST_SDO_IDLE: assert property (cs_n [*8] |-> !sdo)
    else $error("sdo driven between frames");
endmodule : dfr_diag_flags_checker

bind dfr_diag_flags dfr_diag_flags_checker u_dfr_diag_flags_checker (.ref_clk(ref_clk),
  .srst(srst), .cs_n(cs_n), .sdo(sdo), .cal_crc_fail(cal_crc_fail), .dac_code(dac_code),
  .dac_code_inv(dac_code_inv), .digital_fault_summary(digital_fault_summary));

// >>> sim/dfr_spi_host.sv
// serial host model that sends frames and collects readback
module dfr_spi_host (
  // clock
  input wire logic ref_clk,
  // serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle pins: clock still, select high
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8

  task automatic frame(input logic [31:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    @(posedge ref_clk);
    #1 cs_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      #1 sclk = 1'b1;
      sdi = w[31-i];
      repeat (6) @(posedge ref_clk);
      if (i < 24)
        r[23-i] = sdo;
      #1 sclk = 1'b0;
      repeat (6) @(posedge ref_clk);
    end
    #1 cs_n = 1'b1;
    // released data line shows the inverse
    sdi = ~sdi;
    repeat (10) @(posedge ref_clk);
    // return off the edge so the caller's next input change never races the clock
    #1;
  endtask : frame
endmodule : dfr_spi_host

// >>> sim/test_diagnostic_flag_registers.sv
// self-checking bench for the diagnostic flag registers
module test_diagnostic_flag_registers;
  timeunit 1ns;
  timeprecision 100ps;
  // design inputs
  logic ref_clk, srst, crc_enable, cal_refresh_busy, cal_crc_fail, fault_pin;
  logic [15:0] dac_code, dac_code_inv, ana_fault_src, ana_diag_en;
  // pins and outputs
  wire logic sclk, cs_n, sdi, sdo, digital_fault_summary;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [23:0] rx;

  dfr_diag_flags u_dfr_diag_flags (.ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo), .crc_enable(crc_enable), .cal_refresh_busy(cal_refresh_busy),
    .cal_crc_fail(cal_crc_fail), .dac_code(dac_code), .dac_code_inv(dac_code_inv),
    .ana_fault_src(ana_fault_src), .ana_diag_en(ana_diag_en), .fault_pin(fault_pin),
    .digital_fault_summary(digital_fault_summary));
  dfr_spi_host u_dfr_spi_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one frame; n of 0 means the legal length
  task automatic xfer(input logic [23:0] p, input int n, input logic [7:0] bad);
    u_dfr_spi_host.frame({p, u_dfr_spi_host.crc8(p) ^ bad}, n ? n : (crc_enable ? 32 : 24), rx);
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    xfer({3'b100, a, d}, 0, 8'h00);
  endtask : wr

  // request then fetch the answer in the next frame
  task automatic rd(input logic [4:0] a, input logic [15:0] d, input string what);
    xfer({3'b101, a, 16'h0000}, 0, 8'h00);
    xfer({3'b101, 5'h16, 16'h0000}, 0, 8'h00);
    chk(what, {2'b00, ~fault_pin, a, d}, rx);
  endtask : rd

  task automatic t_refresh();
    tick();
    cal_refresh_busy = 1'b1;
    rd(5'h14, 16'h0000, "read in refresh");
    wr(5'h14, 16'h0000);
    rd(5'h14, 16'h0010, "write in refresh");
    cal_refresh_busy = 1'b0;
    wr(5'h14, 16'h0010);
    rd(5'h14, 16'h0000, "access cleared");
    $display("test refresh done");
  endtask : t_refresh

  task automatic t_access();
    wr(5'h16, 16'h0000);
    chk("summary", 24'h000001, {23'h0, digital_fault_summary});
    rd(5'h14, 16'h0010, "read-only write");
    wr(5'h14, 16'h0010);
    xfer({3'b101, 5'h1F, 16'h0000}, 0, 8'h00);
    rd(5'h14, 16'h0010, "unmapped read");
    wr(5'h14, 16'h0010);
    $display("test access done");
  endtask : t_access

  task automatic t_link();
    xfer({3'b101, 5'h15, 16'h0000}, 20, 8'h00);
    xfer({3'b101, 5'h15, 16'h0000}, 32, 8'h00);
    xfer({3'b001, 5'h15, 16'h0000}, 0, 8'h00);
    rd(5'h14, 16'h0006, "count and slip");
    chk("summary", 24'h000000, {23'h0, digital_fault_summary});
    crc_enable = 1'b1;
    wr(5'h14, 16'h0006);
    xfer({3'b101, 5'h15, 16'h0000}, 0, 8'h01);
    xfer({3'b101, 5'h15, 16'h0000}, 24, 8'h00);
    rd(5'h14, 16'h0005, "crc and count");
    wr(5'h14, 16'h0005);
    crc_enable = 1'b0;
    $display("test link done");
  endtask : t_link

  task automatic t_dig();
    tick();
    cal_crc_fail = 1'b1;
    dac_code_inv = 16'h0000;
    tick();
    cal_crc_fail = 1'b0;
    dac_code_inv = 16'hEDCB;
    rd(5'h14, 16'h0060, "sticky sources");
    cal_crc_fail = 1'b1;
    wr(5'h14, 16'h0060);
    rd(5'h14, 16'h0020, "persisting fault");
    cal_crc_fail = 1'b0;
    wr(5'h14, 16'h0020);
    rd(5'h14, 16'h0000, "sources cleared");
    $display("test digital done");
  endtask : t_dig

  task automatic t_analog();
    int pos[10] = '{13, 11, 9, 7, 6, 4, 3, 2, 1, 0};
    foreach (pos[i])
    begin
      tick();
      fault_pin = i[0];
      ana_fault_src[pos[i]] = 1'b1;
      tick();
      ana_fault_src[pos[i]] = 1'b0;
      rd(5'h15, 16'h0001 << pos[i], "analog flag");
      wr(5'h15, 16'h0001 << pos[i]);
    end
    rd(5'h15, 16'h0000, "analog cleared");
    ana_diag_en = 16'h0000;
    ana_fault_src = 16'h2ADF;
    rd(5'h15, 16'h0000, "disabled reads zero");
    $display("test analog done");
  endtask : t_analog

  initial
  begin
    srst = 1'b1;
    crc_enable = 1'b0;
    cal_refresh_busy = 1'b0;
    cal_crc_fail = 1'b0;
    fault_pin = 1'b0;
    dac_code = 16'h1234;
    dac_code_inv = 16'hEDCB;
    ana_fault_src = 16'h0000;
    ana_diag_en = 16'hFFFF;
    repeat (8) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (4) @(posedge ref_clk);
    t_refresh();
    t_access();
    t_link();
    t_dig();
    t_analog();
    results();
  end
endmodule : test_diagnostic_flag_registers
